// >>> include/dcf_pkg.sv
// constants shared by the dual-clock flag fifo and its staging buffer
// assumes one system clock samples every pin through two flip-flops
package dcf_pkg;
  localparam int DCF_DATA_W      = 18;
  localparam int DCF_OFS_W       = 12;
  localparam int DCF_DEPTH_DEF   = 64;
  localparam int DCF_STAGE_DEPTH = 8;
  localparam int DCF_SYNC_W      = 28;
  localparam logic [11:0] DCF_OFS_64   = 12'h007;
  localparam logic [11:0] DCF_OFS_256  = 12'h01f;
  localparam logic [11:0] DCF_OFS_512  = 12'h03f;
  localparam logic [11:0] DCF_OFS_BIG  = 12'h07f;
  localparam logic [17:0] DCF_WORD_RST = 18'h00000;

  // offset register walk: empty then full, gray order
  typedef enum logic {
    DCF_SEL_EMPTY = 1'b0,
    DCF_SEL_FULL  = 1'b1
  } dcf_sel_t;

  function automatic logic [11:0] dcf_ofs_default(input int depth);
    if (depth <= 64)
      return DCF_OFS_64;
    else if (depth <= 256)
      return DCF_OFS_256;
    else if (depth <= 512)
      return DCF_OFS_512;
    else
      return DCF_OFS_BIG;
  endfunction
endpackage

// >>> logic/dcf_fifo.sv
// dual-clock 18-bit fifo with programmable flags, plus its staging buffer
// assumes write and read clocks are pins, oversampled by ref_clk_i
`timescale 1ns/100ps

module dcf_stage_fifo #(
  parameter int W = 18,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         flush_i,
  // filling side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // draining side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wa_reg;
  logic [AW-1:0] ra_reg;
  logic [AW:0]   cnt_reg;
  wire           push = in_valid_i & in_ready_o;
  wire           pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (cnt_reg != (AW+1)'(D));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem[ra_reg];

  always_ff @(posedge ref_clk_i) begin
    if (push)
      mem[wa_reg] <= in_data_i;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wa_reg  <= '0;
      ra_reg  <= '0;
      cnt_reg <= '0;
    end else if (flush_i) begin
      wa_reg  <= '0;
      ra_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push)
        wa_reg <= (wa_reg == AW'(D-1)) ? '0 : wa_reg + 1'b1;
      if (pop)
        ra_reg <= (ra_reg == AW'(D-1)) ? '0 : ra_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int DEPTH = DCF_DEPTH_DEF
) (
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  // write port pins
  input  wire logic                  write_clk_i,
  input  wire logic                  write_en_n_i,
  input  wire logic [DCF_DATA_W-1:0] input_word_i,
  // read port pins
  input  wire logic                  read_clk_i,
  input  wire logic                  read_en_n_i,
  input  wire logic                  out_en_n_i,
  input  wire logic                  read_token_i,
  output logic [DCF_DATA_W-1:0]      output_word_o,
  output logic                       output_word_oe_o,
  // control pins
  input  wire logic                  offset_program_sel_n_i,
  input  wire logic                  replay_pulse_i,
  input  wire logic                  flag_sync_select_i,
  input  wire logic                  master_clear_n_i,
  // flags
  output logic                       full_indicator_n_o,
  output logic                       empty_indicator_n_o,
  output logic                       near_empty_indicator_n_o,
  output logic                       near_full_indicator_n_o,
  output logic                       half_level_indicator_n_o
);
  import dcf_pkg::*;

  localparam int PW = $clog2(DEPTH) + 1;
  localparam int CW = ((PW > DCF_OFS_W) ? PW : DCF_OFS_W) + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_P  = PW'(DEPTH / 2);
  localparam logic [11:0]   OFS_RST = dcf_ofs_default(DEPTH);

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i+1]);
    end
    return b;
  endfunction

  // every pin passes two flops; data lags exactly like its clock
  logic [DCF_SYNC_W-1:0] pin_s1_reg;
  logic [DCF_SYNC_W-1:0] pin_s2_reg;
  logic                  wclk_s3_reg;
  logic                  rclk_s3_reg;
  wire [DCF_SYNC_W-1:0]  pin_raw = {write_clk_i, read_clk_i, write_en_n_i,
                                    read_en_n_i, out_en_n_i, read_token_i,
                                    offset_program_sel_n_i, replay_pulse_i,
                                    flag_sync_select_i, master_clear_n_i,
                                    input_word_i};

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_reg  <= '0;
      pin_s2_reg  <= '0;
      wclk_s3_reg <= 1'b0;
      rclk_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg  <= pin_raw;
      pin_s2_reg  <= pin_s1_reg;
      wclk_s3_reg <= pin_s2_reg[27];
      rclk_s3_reg <= pin_s2_reg[26];
    end
  end

  wire                  wen_s   = pin_s2_reg[25];
  wire                  ren_s   = pin_s2_reg[24];
  wire                  oe_n_s  = pin_s2_reg[23];
  wire                  token_s = pin_s2_reg[22];
  wire                  ld_n_s  = pin_s2_reg[21];
  wire                  rt_s    = pin_s2_reg[20];
  wire                  async_s = pin_s2_reg[19];
  wire                  clr_s   = ~pin_s2_reg[18];
  wire [DCF_DATA_W-1:0] din_s   = pin_s2_reg[17:0];
  wire                  wr_ev   = pin_s2_reg[27] & ~wclk_s3_reg;
  wire                  rd_ev   = pin_s2_reg[26] & ~rclk_s3_reg;

  // state
  logic [DCF_DATA_W-1:0] mem [DEPTH];
  logic [PW-1:0]         acc_ptr_reg;
  logic [PW-1:0]         wr_ptr_reg;
  logic [PW-1:0]         wr_gray_reg;
  logic [PW-1:0]         rd_ptr_reg;
  logic [11:0]           near_empty_distance_reg;
  logic [11:0]           near_full_distance_reg;
  dcf_sel_t              wsel_reg;
  dcf_sel_t              rsel_reg;
  logic [DCF_DATA_W-1:0] out_word_reg;
  logic                  out_oe_reg;
  logic                  full_n_reg;
  logic                  empty_n_reg;
  logic                  near_empty_n_reg;
  logic                  near_full_n_reg;
  logic                  half_n_reg;

  // staging buffer between pins and array
  logic                  stg_rdy;
  logic                  stg_vld;
  logic [DCF_DATA_W-1:0] stg_data;
  wire                   drain = stg_vld & ~rt_s;

  // write side, counts accepted words so full sees staged ones too
  wire [PW-1:0] acc_cnt  = acc_ptr_reg - rd_ptr_reg;
  wire          accept   = wr_ev & ~wen_s & ld_n_s & full_n_reg & stg_rdy
                           & (acc_cnt < DEPTH_P);
  wire          ofs_wr   = wr_ev & ~wen_s & ~ld_n_s;
  wire [PW-1:0] acc_next = acc_cnt + PW'(accept);

  // read side sees the committed pointer through its gray copy
  wire [PW-1:0] wr_seen  = gray2bin(wr_gray_reg);
  wire [PW-1:0] rd_cnt   = wr_seen - rd_ptr_reg;
  wire          ofs_rd   = rd_ev & ~ren_s & ~ld_n_s;
  wire          data_rd  = rd_ev & ~ren_s & ld_n_s & empty_n_reg
                           & (rd_cnt != '0);
  wire [PW-1:0] rd_next  = rd_ptr_reg + PW'(data_rd);
  wire [PW-1:0] rd_cnt_n = wr_seen - rd_next;

  // compare one bit wider than the offset: an offset may exceed the depth
  wire          pae_lvl  = ~(CW'(rd_cnt_n) <= CW'(near_empty_distance_reg));
  wire          paf_lvl  = ~((CW'(acc_next) + CW'(near_full_distance_reg))
                             >= CW'(DEPTH));

  dcf_stage_fifo #(
    .W (DCF_DATA_W),
    .D (DCF_STAGE_DEPTH)
  ) u_stage (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (clr_s),
    .in_valid_i  (accept),
    .in_ready_o  (stg_rdy),
    .in_data_i   (din_s),
    .out_valid_o (stg_vld),
    .out_ready_i (~rt_s),
    .out_data_o  (stg_data)
  );

  always_ff @(posedge ref_clk_i) begin
    if (drain)
      mem[wr_ptr_reg[PW-2:0]] <= stg_data;
  end

  // pointers and offset registers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_ptr_reg             <= '0;
      wr_ptr_reg              <= '0;
      wr_gray_reg             <= '0;
      rd_ptr_reg              <= '0;
      near_empty_distance_reg <= OFS_RST;
      near_full_distance_reg  <= OFS_RST;
      wsel_reg                <= DCF_SEL_EMPTY;
      rsel_reg                <= DCF_SEL_EMPTY;
    end else if (clr_s) begin
      acc_ptr_reg             <= '0;
      wr_ptr_reg              <= '0;
      wr_gray_reg             <= '0;
      rd_ptr_reg              <= '0;
      near_empty_distance_reg <= OFS_RST;
      near_full_distance_reg  <= OFS_RST;
      wsel_reg                <= DCF_SEL_EMPTY;
      rsel_reg                <= DCF_SEL_EMPTY;
    end else begin
      acc_ptr_reg <= acc_ptr_reg + PW'(accept);
      wr_ptr_reg  <= wr_ptr_reg + PW'(drain);
      wr_gray_reg <= bin2gray(wr_ptr_reg);
      // replay rewinds read side only; valid up to depth writes
      if (rt_s)
        rd_ptr_reg <= '0;
      else
        rd_ptr_reg <= rd_next;
      if (ofs_wr) begin
        if (wsel_reg == DCF_SEL_EMPTY)
          near_empty_distance_reg <= din_s[DCF_OFS_W-1:0];
        else
          near_full_distance_reg <= din_s[DCF_OFS_W-1:0];
        wsel_reg <= dcf_sel_t'(~wsel_reg);
      end
      if (ofs_rd)
        rsel_reg <= dcf_sel_t'(~rsel_reg);
    end
  end

  // output register and drive
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_word_reg <= DCF_WORD_RST;
      out_oe_reg   <= 1'b0;
    end else begin
      out_oe_reg <= ~oe_n_s & token_s;
      if (clr_s)
        out_word_reg <= DCF_WORD_RST;
      else if (ofs_rd)
        out_word_reg <= (rsel_reg == DCF_SEL_EMPTY)
                        ? {6'h00, near_empty_distance_reg}
                        : {6'h00, near_full_distance_reg};
      else if (data_rd)
        out_word_reg <= mem[rd_ptr_reg[PW-2:0]];
    end
  end

  // flags; replay refreshes them from the rewound pointers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      full_n_reg       <= 1'b1;
      empty_n_reg      <= 1'b0;
      near_empty_n_reg <= 1'b0;
      near_full_n_reg  <= 1'b1;
      half_n_reg       <= 1'b1;
    end else if (clr_s) begin
      full_n_reg       <= 1'b1;
      empty_n_reg      <= 1'b0;
      near_empty_n_reg <= 1'b0;
      near_full_n_reg  <= 1'b1;
      half_n_reg       <= 1'b1;
    end else begin
      if (wr_ev | rt_s)
        full_n_reg <= (acc_next != DEPTH_P);
      if (rd_ev | rt_s)
        empty_n_reg <= (rd_cnt_n != '0);
      if (async_s | rd_ev | rt_s)
        near_empty_n_reg <= pae_lvl;
      if (async_s | wr_ev | rt_s)
        near_full_n_reg <= paf_lvl;
      half_n_reg <= ~(acc_cnt > HALF_P);
    end
  end

  assign output_word_o            = out_word_reg;
  assign output_word_oe_o         = out_oe_reg;
  assign full_indicator_n_o       = full_n_reg;
  assign empty_indicator_n_o      = empty_n_reg;
  assign near_empty_indicator_n_o = near_empty_n_reg;
  assign near_full_indicator_n_o  = near_full_n_reg;
  assign half_level_indicator_n_o = half_n_reg;

  chk_full_blocks_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (wr_ev && !full_n_reg && !clr_s) |=> $stable(acc_ptr_reg))
    else $error("write taken while full");

  chk_count_never_over: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    acc_cnt <= DEPTH_P)
    else $error("buffer count above depth");

  chk_empty_holds_word: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (rd_ev && !empty_n_reg && ld_n_s && !clr_s) |=> $stable(out_word_reg))
    else $error("output word changed on empty read");

  chk_empty_on_edges: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (!rd_ev && !rt_s && !clr_s) |=> $stable(empty_n_reg))
    else $error("empty flag moved off read edge");

  chk_full_on_edges: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (!wr_ev && !rt_s && !clr_s) |=> $stable(full_n_reg))
    else $error("full flag moved off write edge");

  chk_drive_follows_ctl: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 (out_oe_reg == $past(~oe_n_s & token_s)))
    else $error("output drive does not follow control");

  chk_replay_rewinds: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (rt_s && !clr_s) |=> (rd_ptr_reg == '0) && $stable(acc_ptr_reg))
    else $error("replay did not rewind read pointer");

  chk_offset_alternates: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    (ofs_wr && !clr_s) |=> (wsel_reg != $past(wsel_reg))
                           && $stable(acc_ptr_reg))
    else $error("offset write did not alternate");

  chk_clear_defaults: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    clr_s |=> (near_empty_distance_reg == OFS_RST)
              && (near_full_distance_reg == OFS_RST) && !empty_n_reg)
    else $error("master clear left state behind");

  chk_half_level: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !clr_s |=> (half_n_reg == ($past(acc_cnt) <= HALF_P)))
    else $error("half flag wrong for count");
endmodule

// >>> tb/dcf_pin_partner.sv
// pin-level producer and consumer facing both ports of the flag fifo
// assumes ref_clk_i is the fifo's oversampling clock; clocks idle low
`timescale 1ns/100ps

module dcf_pin_partner (
  // system clock
  input  wire logic                         ref_clk_i,
  // producer pins
  output logic                              write_clk_o,
  output logic                              write_en_n_o,
  output logic [dcf_pkg::DCF_DATA_W-1:0]    input_word_o,
  // consumer pins
  output logic                              read_clk_o,
  output logic                              read_en_n_o
);
  import dcf_pkg::*;
  // pin clocks need three sampling cycles per phase
  localparam int HALF = 3;

  initial begin
    write_clk_o  = 1'b0;
    write_en_n_o = 1'b1;
    input_word_o = '0;
    read_clk_o   = 1'b0;
    read_en_n_o  = 1'b1;
  end

  // data and strobe settle a cycle before the rise and stay past the fall
  task automatic push_word(input logic [DCF_DATA_W-1:0] d);
    @(negedge ref_clk_i);
    input_word_o = d;
    write_en_n_o = 1'b0;
    @(negedge ref_clk_i);
    write_clk_o = 1'b1;
    repeat (HALF) @(negedge ref_clk_i);
    write_clk_o = 1'b0;
    repeat (HALF) @(negedge ref_clk_i);
    write_en_n_o = 1'b1;
    input_word_o = ~d;  // released bus never shows the stale word
  endtask

  task automatic pull_word();
    @(negedge ref_clk_i);
    read_en_n_o = 1'b0;
    @(negedge ref_clk_i);
    read_clk_o = 1'b1;
    repeat (HALF) @(negedge ref_clk_i);
    read_clk_o = 1'b0;
    repeat (HALF) @(negedge ref_clk_i);
    read_en_n_o = 1'b1;
  endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the dual-clock flag fifo
// assumes the pin partner drives both ports; one 20 MHz system clock
`timescale 1ns/100ps

module tb_top;
  import dcf_pkg::*;
  localparam int DEPTH = DCF_DEPTH_DEF;
  logic                  ref_clk = 1'b0;
  logic                  rst_b   = 1'b0;
  logic                  oe_n    = 1'b0;
  logic                  token   = 1'b1;
  logic                  ld_n    = 1'b1;
  logic                  replay  = 1'b0;
  logic                  mclr_n  = 1'b1;
  logic                  flag_sync_select   = 1'b0;
  logic                  wclk, wen_n, rclk, ren_n, q_oe;
  logic [DCF_DATA_W-1:0] din, q;
  logic                  full_n, empty_n, ne_n, nf_n, half_n;
  wire  [DCF_DATA_W-1:0] q_bus;
  logic                  full_hi_n, empty_hi_n;
  logic [DCF_DATA_W-1:0] q_hi;
  // composite flags of the 36-bit pair: low if either side is low
  wire                   comp_empty_n = empty_n & empty_hi_n;
  wire                   comp_full_n  = full_n & full_hi_n;
  logic [31:0]           seed = 32'h000098ed;
  int                    n_fail = 0;
  int                    comparisons = 0;

  always #25 ref_clk = ~ref_clk;
  assign q_bus = q_oe ? q : {DCF_DATA_W{1'bz}};

  dcf_pin_partner i_partner (.ref_clk_i(ref_clk), .write_clk_o(wclk),
    .write_en_n_o(wen_n), .input_word_o(din), .read_clk_o(rclk),
    .read_en_n_o(ren_n));

  dcf_fifo #(.DEPTH(DEPTH)) i_dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .write_clk_i(wclk), .write_en_n_i(wen_n), .input_word_i(din),
    .read_clk_i(rclk), .read_en_n_i(ren_n), .out_en_n_i(oe_n),
    .read_token_i(token), .output_word_o(q), .output_word_oe_o(q_oe),
    .offset_program_sel_n_i(ld_n), .replay_pulse_i(replay),
    .flag_sync_select_i(flag_sync_select), .master_clear_n_i(mclr_n),
    .full_indicator_n_o(full_n), .empty_indicator_n_o(empty_n),
    .near_empty_indicator_n_o(ne_n), .near_full_indicator_n_o(nf_n),
    .half_level_indicator_n_o(half_n));

  // upper half of a 36-bit word; every control shared
  dcf_fifo #(.DEPTH(DEPTH)) i_dut_hi (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .write_clk_i(wclk), .write_en_n_i(wen_n), .input_word_i(~din),
    .read_clk_i(rclk), .read_en_n_i(ren_n), .out_en_n_i(oe_n),
    .read_token_i(token), .output_word_o(q_hi), .output_word_oe_o(),
    .offset_program_sel_n_i(ld_n), .replay_pulse_i(replay),
    .flag_sync_select_i(flag_sync_select), .master_clear_n_i(mclr_n),
    .full_indicator_n_o(full_hi_n), .empty_indicator_n_o(empty_hi_n),
    .near_empty_indicator_n_o(), .near_full_indicator_n_o(),
    .half_level_indicator_n_o());

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_sim();
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // first edge after writes may only refresh the empty flag
  task automatic pop(input logic [17:0] exp);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < 3 && !ok; i++) begin
      ok = (comp_empty_n === 1'b1);
      i_partner.pull_word();
    end
    chk(ok, 1'b1);
    if (!ok) end_sim();
    chk(q, exp);
    chk(q_hi, ~exp);
    chk(q_oe, !oe_n && token);
    chk(q_bus, (!oe_n && token) ? exp : {18{1'bz}});
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    end_sim();
  end

  initial begin : main
    logic [31:0] r;
    logic [11:0] ofs_e, ofs_f, a, b;
    logic [17:0] exp;
    logic [17:0] mq[$];
    logic [17:0] wl[$];
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({empty_n, full_n, half_n, ne_n, nf_n}, 18'h0000d);
    ld_n = 1'b0;
    repeat (2) begin
      i_partner.pull_word();
      chk(q, {6'h00, DCF_OFS_64});
    end
    r = rnd();
    a = r[11:0];
    b = r[23:12];
    ofs_e = 12'(r[28:24]) + 12'h001;
    r = rnd();
    ofs_f = 12'(r[4:0]) + 12'h001;
    i_partner.push_word({r[31:26], a});
    i_partner.push_word({r[25:20], b});
    i_partner.push_word({r[19:14], ofs_e});
    ld_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    ld_n = 1'b0;
    i_partner.push_word({r[13:8], ofs_f});
    i_partner.pull_word();
    chk(q, {6'h00, ofs_e});
    i_partner.pull_word();
    chk(q, {6'h00, ofs_f});
    ld_n = 1'b1;
    for (int cnt = 1; cnt <= DEPTH; cnt++) begin
      r = rnd();
      mq.push_back(r[17:0]);
      i_partner.push_word(r[17:0]);
      chk(full_n, cnt < DEPTH);
      chk(half_n, cnt <= DEPTH / 2);
      chk(nf_n, cnt < DEPTH - ofs_f);
    end
    i_partner.push_word(18'h2aaaa);
    chk(full_n, 1'b0);
    chk(comp_full_n, 1'b0);
    chk(ne_n, 1'b0);
    for (int cnt = DEPTH - 1; cnt >= 0; cnt--) begin
      r = rnd();
      oe_n = r[0];
      token = r[1] | r[2];
      exp = mq.pop_front();
      pop(exp);
      chk(empty_n, cnt != 0);
      chk(ne_n, cnt > ofs_e);
      chk(half_n, cnt <= DEPTH / 2);
    end
    i_partner.pull_word();
    chk(q, exp);
    chk(empty_n, 1'b0);
    oe_n = 1'b0;
    token = 1'b1;
    mclr_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    mclr_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk({empty_n, full_n, half_n, ne_n, nf_n}, 18'h0000d);
    chk(q, DCF_WORD_RST);
    ld_n = 1'b0;
    i_partner.pull_word();
    chk(q, {6'h00, DCF_OFS_64});
    ld_n = 1'b1;
    repeat (5) begin
      r = rnd();
      wl.push_back(r[17:0]);
      i_partner.push_word(r[17:0]);
    end
    for (int i = 0; i < 3; i++) pop(wl[i]);
    @(negedge ref_clk);
    replay = 1'b1;
    repeat (4) @(negedge ref_clk);
    replay = 1'b0;
    repeat (8) @(negedge ref_clk); // strobes idle over recovery
    repeat (2) begin
      r = rnd();
      wl.push_back(r[17:0]);
      i_partner.push_word(r[17:0]);
    end
    for (int i = 0; i < 7; i++) pop(wl[i]);
    chk(empty_n, 1'b0);
    // async near flags move without any read clock edge
    flag_sync_select = 1'b1;
    repeat (8) begin
      r = rnd();
      i_partner.push_word(r[17:0]);
    end
    repeat (4) @(negedge ref_clk);
    chk(ne_n, 1'b1);
    end_sim();
  end
endmodule
